// ### hw/ebms_pkg.sv
/*
 * constants and carriers for the external bus mode sequencer.
 * assumes one 100 MHz clock and an active-low asynchronous reset.
 */
// Notes on behaviour
// - on external bus request, release bus and drive bus grant low.
// - while master owns bus, keep decoding its address to chip selects.
// - external master can never reach internal registers.
// - each chip select has its own bus format.
// - each chip select has its own clocks-per-state count.
// - reset gives native format; native passes CPU signals unchanged.
// - legacy cycles start in T1 with address and chip select driven.
// - legacy read asserts read strobe and memory or io request in T2.
// - legacy write asserts write strobe and memory or io request in T2.
// - legacy: wait low before T2 ends adds waits until wait high.
// - legacy T3 changes nothing; read data captured at T3 end.
// - legacy states last 1 to 15 clocks.
// - four-state offers multiplexing; address low byte on data in T1.
// - four-state T1 drives address, chip select; latch enable high half T1.
// - four-state read asserts read strobe and request in T2.
// - four-state T3 unchanged; ready low in any T3 clock adds waits.
// - four-state read captures data at T4 start, drops read strobe.
// - four-state separate write drives data with address in T1.
// - four-state write strobe T2 to T4 start; address, data held.
// - four-state states last 2 to 15 clocks.
// - per chip select wait count adds 0 to 7 clocks.
package ebms_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 8;
	localparam int NUM_CS = 4;
	localparam logic [3:0] CPS_MIN_LEGACY = 4'h1;
	localparam logic [3:0] CPS_MIN_FOUR = 4'h2;
	localparam logic [3:0] CPS_MAX = 4'hF;
	localparam logic [3:0] CPS_RESET = 4'h2;
	localparam logic [2:0] WAIT_RESET = 3'h0;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [1:0] {
		EBMS_FMT_NATIVE = 2'h0,
		EBMS_FMT_LEGACY = 2'h1,
		EBMS_FMT_FOUR = 2'h2
	} ebms_fmt_t;

	// one cpu access request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic is_write;
		logic is_io;
		logic [NUM_CS-1:0] cs_sel;
	} ebms_req_t;

	// per chip select configuration
	typedef struct packed {
		ebms_fmt_t fmt;
		logic muxed;
		logic [3:0] cps;
		logic [2:0] wait_cnt;
	} ebms_cfg_t;

	localparam int REQ_W = $bits(ebms_req_t);
endpackage

// ### hw/ebms_fifo.sv
/*
 * request fifo for the external bus mode sequencer.
 * assumes a single clock domain.
 */
`timescale 1ns/100ps
module ebms_fifo
	import ebms_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr_reg;
	logic [AW:0] rptr_reg;
	logic push;
	logic pop;

	assign in_ready = (wptr_reg - rptr_reg) != (AW+1)'(DEPTH);
	assign out_valid = wptr_reg != rptr_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rptr_reg[AW-1:0]];

	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem[wptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop)
			begin
				rptr_reg <= rptr_reg + 1'b1;
			end
		end
	end
endmodule

// ### hw/ebms_top.sv
/*
 * per chip select bus cycle sequencer: native, three-state legacy and
 * four-state latch-enable formats, wait insertion, bus hand-over.
 * assumes requests come already decoded to one chip select and that
 * pin inputs are synchronous to mclk.
 */
`timescale 1ns/100ps
module ebms_top
	import ebms_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	// cpu request side
	input wire logic req_valid,
	output logic req_ready,
	input wire ebms_req_t req,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	// per chip select configuration
	input wire ebms_cfg_t [NUM_CS-1:0] cs_cfg,
	// chip select decode of external master address
	input wire logic [NUM_CS-1:0] ext_cs_match,
	// external master may not reach internal registers
	input wire logic ext_reg_hit,
	output logic int_reg_block,
	// pins
	input wire logic bus_request_n,
	output logic bus_grant_n,
	output logic [ADDR_W-1:0] addr_out,
	output logic addr_oe,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	input wire logic [DATA_W-1:0] data_in,
	output logic [NUM_CS-1:0] cs_n,
	output logic memory_request_n,
	output logic io_request_n,
	output logic rd_n,
	output logic wr_n,
	output logic ale,
	input wire logic wait_n
);
	// ***********************************************
	// state machine
	// ***********************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_T1 = 3'b001,
		ST_T2 = 3'b011,
		ST_T3 = 3'b010,
		ST_WAIT = 3'b110,
		ST_T4 = 3'b111,
		ST_HAND = 3'b100
	} ebms_st_t;

	ebms_st_t st_reg;
	ebms_st_t st_next;
	ebms_req_t cur_reg;
	ebms_cfg_t cfg_reg;
	logic [3:0] cnt_reg;
	logic [2:0] pw_reg;
	logic [3:0] half_reg;
	logic state_end;
	logic fifo_valid;
	logic take;
	ebms_req_t fifo_req;
	logic [NUM_CS-1:0] req_cs;
	ebms_cfg_t sel_cfg;
	logic pw_phase;

	// ***********************************************
	// request fifo
	// ***********************************************
	ebms_fifo #(
		.WIDTH(REQ_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_b(rst_b),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data(req),
		.out_valid(fifo_valid),
		.out_ready(take),
		.out_data(fifo_req)
	);

	// ***********************************************
	// helper functions
	// ***********************************************
	// clamp of clocks-per-state to the legal range of a format
	function automatic logic [3:0] clamp_cps(ebms_cfg_t c);
		logic [3:0] lo;
		lo = (c.fmt == EBMS_FMT_FOUR) ? CPS_MIN_FOUR : CPS_MIN_LEGACY;
		clamp_cps = (c.cps < lo) ? lo : c.cps;
	endfunction

	// lowest numbered selected chip select
	function automatic logic [1:0] cs_index(logic [NUM_CS-1:0] s);
		cs_index = 2'h0;
		for (int i = NUM_CS - 1; i >= 0; i--)
		begin
			if (s[i])
			begin
				cs_index = 2'(i);
			end
		end
	endfunction

	assign take = (st_reg == ST_IDLE) && fifo_valid && bus_request_n;
	assign state_end = (cnt_reg == 4'h1);
	// programmed waits: end of T2, or of the single native state
	assign pw_phase = (cfg_reg.fmt == EBMS_FMT_NATIVE) ? (st_reg == ST_T1)
		: (st_reg == ST_T2);

	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg)
			ST_IDLE:
			begin
				if (!bus_request_n)
				begin
					st_next = ST_HAND;
				end
				else if (take)
				begin
					st_next = ST_T1;
				end
			end
			ST_T1:
			begin
				if (state_end && cfg_reg.fmt != EBMS_FMT_NATIVE)
				begin
					st_next = ST_T2;
				end
				else if (state_end && pw_reg == 3'h0)
				begin
					st_next = ST_IDLE;
				end
			end
			ST_T2:
			begin
				if (state_end && pw_reg == 3'h0)
				begin
					st_next = ST_T3;
				end
			end
			ST_T3:
			begin
				// four-state ready is watched through T3
				if (cfg_reg.fmt == EBMS_FMT_FOUR && !wait_n)
				begin
					st_next = ST_WAIT;
				end
				else if (state_end)
				begin
					st_next = (cfg_reg.fmt == EBMS_FMT_FOUR) ? ST_T4 : ST_IDLE;
				end
			end
			ST_WAIT:
			begin
				if (wait_n)
				begin
					st_next = (cfg_reg.fmt == EBMS_FMT_FOUR) ? ST_T4 : ST_T3;
				end
			end
			ST_T4:
			begin
				if (state_end)
				begin
					st_next = ST_IDLE;
				end
			end
			ST_HAND:
			begin
				if (bus_request_n)
				begin
					st_next = ST_IDLE;
				end
			end
			default:
			begin
				st_next = ST_IDLE;
			end
		endcase
		// legacy wait: sampled low before T2 ends
		if (st_reg == ST_T2 && state_end && pw_reg == 3'h0 && !wait_n
			&& cfg_reg.fmt == EBMS_FMT_LEGACY)
		begin
			st_next = ST_WAIT;
		end
	end

	// ***********************************************
	// sequencing registers
	// ***********************************************
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg <= ST_IDLE;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ***********************************************
	// configuration select
	// ***********************************************
	assign req_cs = fifo_req.cs_sel;

	// config of the chip select at the fifo head, cps raised to its minimum
	always_comb
	begin
		sel_cfg = cs_cfg[cs_index(req_cs)];
		sel_cfg.cps = clamp_cps(cs_cfg[cs_index(req_cs)]);
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cur_reg <= '0;
			cfg_reg <= '{EBMS_FMT_NATIVE, 1'b0, CPS_RESET, WAIT_RESET};
		end
		else if (take)
		begin
			cur_reg <= fifo_req;
			cfg_reg <= sel_cfg;
		end
	end

	// ***********************************************
	// cycle counters
	// ***********************************************
	// per-state cycle counter; native runs one state of cps clocks
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_reg <= 4'h1;
			half_reg <= 4'h0;
		end
		else if (take)
		begin
			cnt_reg <= sel_cfg.cps;
			half_reg <= sel_cfg.cps >> 1;
		end
		else if (st_next != st_reg)
		begin
			cnt_reg <= cfg_reg.cps;
		end
		else if (!state_end)
		begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end

	// programmable wait count, spent at the end of T2, or of T1 in native format
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pw_reg <= WAIT_RESET;
		end
		else if (take)
		begin
			pw_reg <= sel_cfg.wait_cnt;
		end
		else if (pw_phase && state_end && pw_reg != 3'h0)
		begin
			pw_reg <= pw_reg - 3'h1;
		end
	end

	// ***********************************************
	// read capture and response
	// ***********************************************
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			if ((st_reg == ST_T1 && st_next == ST_IDLE)
				|| (st_reg == ST_T3 && st_next == ST_IDLE)
				|| (st_reg == ST_T4 && st_next == ST_IDLE))
			begin
				rsp_valid <= 1'b1;
			end
			if (!cur_reg.is_write && st_reg == ST_T3 && st_next == ST_IDLE)
			begin
				rsp_rdata <= data_in;
			end
			if (!cur_reg.is_write && st_reg == ST_T1 && st_next == ST_IDLE)
			begin
				rsp_rdata <= data_in;
			end
			if (!cur_reg.is_write && st_next == ST_T4 && st_reg != ST_T4)
			begin
				rsp_rdata <= data_in;
			end
		end
	end

	// ***********************************************
	// pin drive
	// ***********************************************
	logic active;
	logic strobe_on;
	logic native;
	logic four;
	logic t1_first_half;

	assign active = st_reg inside {ST_T1, ST_T2, ST_T3, ST_WAIT, ST_T4};
	assign native = cfg_reg.fmt == EBMS_FMT_NATIVE;
	assign four = cfg_reg.fmt == EBMS_FMT_FOUR;
	// native: strobes from T1 on, no reshaping
	assign strobe_on = native ? active
		: (st_reg inside {ST_T2, ST_T3, ST_WAIT});
	assign t1_first_half = (st_reg == ST_T1) && (cnt_reg > half_reg);

	// ***********************************************
	// bus hand-over
	// ***********************************************
	// grant and register guard follow the hand-over state

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_grant_n <= 1'b1;
			int_reg_block <= 1'b0;
		end
		else
		begin
			bus_grant_n <= !(st_next == ST_HAND);
			int_reg_block <= (st_next == ST_HAND) && ext_reg_hit;
		end
	end

	always_comb
	begin
		addr_out = cur_reg.addr;
		addr_oe = active && bus_grant_n;
		data_out = cur_reg.wdata;
		data_oe = 1'b0;
		if (active && four && cfg_reg.muxed && st_reg == ST_T1)
		begin
			data_out = cur_reg.addr[DATA_W-1:0];
			data_oe = 1'b1;
		end
		else if (active && cur_reg.is_write)
		begin
			data_oe = four && !cfg_reg.muxed ? 1'b1
				: (st_reg != ST_T1) || native;
		end
		if (!bus_grant_n)
		begin
			cs_n = ~ext_cs_match;
		end
		else
		begin
			cs_n = active ? ~cur_reg.cs_sel : {NUM_CS{1'b1}};
		end
		memory_request_n = !(strobe_on && !cur_reg.is_io);
		io_request_n = !(strobe_on && cur_reg.is_io);
		rd_n = !(strobe_on && !cur_reg.is_write);
		wr_n = !(strobe_on && cur_reg.is_write);
		ale = four && t1_first_half;
	end
endmodule

// ### verif/ebms_monitor.sv
/* checker on the sequencer top ports.
   assumes a bind into ebms_top and one clock domain. */
`timescale 1ns/100ps
module ebms_monitor
	import ebms_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic bus_request_n,
	input wire logic bus_grant_n,
	input wire logic [NUM_CS-1:0] ext_cs_match,
	input wire logic [NUM_CS-1:0] cs_n,
	input wire logic ext_reg_hit,
	input wire logic int_reg_block,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic memory_request_n,
	input wire logic io_request_n,
	input wire logic ale,
	input wire logic addr_oe,
	input wire logic data_oe,
	input wire logic rsp_valid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	grant_cause_a: assert property
		($fell(bus_grant_n) |-> !$past(bus_request_n)) else $error("grant");
	follow_cs_a: assert property
		(!bus_grant_n |-> cs_n == ~ext_cs_match) else $error("master cs");
	reg_guard_a: assert property
		(!bus_grant_n && ext_reg_hit |=> int_reg_block) else $error("guard");
	bus_quiet_a: assert property
		(!bus_grant_n |-> rd_n && wr_n && !addr_oe && !data_oe && !rsp_valid)
		else $error("bus not released");
	strobe_req_a: assert property
		(!(rd_n && wr_n) |-> memory_request_n ^ io_request_n)
		else $error("request line");
	strobe_cs_a: assert property
		(!(rd_n && wr_n) |-> $countones(~cs_n) == 1) else $error("strobe cs");
	ale_shape_a: assert property
		(ale |-> rd_n && wr_n && addr_oe && $countones(~cs_n) == 1)
		else $error("latch enable");
	ale_short_a: assert property
		($rose(ale) |-> ##[1:8] !ale) else $error("latch width");
	cover property (!bus_grant_n);
	cover property ($rose(ale));
	cover property (rsp_valid);
endmodule

// ### verif/ebms_mem_model.sv
/* far side memory: 16 bytes with a stretchable wait.
   assumes split data pins and active-low strobes. */
`timescale 1ns/100ps
module ebms_mem_model
	import ebms_pkg::*;
(
	input wire logic mclk,
	input wire logic [ADDR_W-1:0] addr_out,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic [NUM_CS-1:0] cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [3:0] stall,
	output logic [DATA_W-1:0] data_in,
	output logic wait_n
);
	logic [DATA_W-1:0] mem_reg [16];
	logic [DATA_W-1:0] last_reg = 8'h00;
	logic [3:0] cnt_reg = 4'h0;
	logic sel_reg = 1'b0;
	wire logic sel = !(&cs_n);
	wire logic st = !(rd_n && wr_n) && sel;
	// undriven bus keeps moving
	assign data_in = (!rd_n && sel) ? mem_reg[addr_out[3:0]] : ~last_reg;
	assign wait_n = cnt_reg == 4'h0;
	always @(posedge mclk)
		last_reg <= data_in;
	always @(posedge mclk)
		if (!wr_n && sel)
			mem_reg[addr_out[3:0]] <= data_out;
	always @(posedge mclk)
	begin
		sel_reg <= st;
		if (st && !sel_reg)
			cnt_reg <= stall;
		else if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
	end
endmodule

// ### verif/ebms_top_bench.sv
/* self-checking bench for the sequencer with memory model.
   assumes the files under hw/ and the monitor. */
`timescale 1ns/100ps
`define CHK(n, e, v) \
	begin \
		checked++; \
		if ((v) !== (e)) \
		begin \
			n_errors++; \
			$display("Error %s exp %0h got %0h", n, e, v); \
		end \
	end
module ebms_top_bench
	import ebms_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic req_valid = 1'b0;
	logic bus_request_n = 1'b1;
	logic ext_reg_hit = 1'b0;
	logic [NUM_CS-1:0] ext_cs_match = 4'h0;
	logic [3:0] stall = 4'h0;
	ebms_req_t req = '0;
	ebms_cfg_t [NUM_CS-1:0] cs_cfg = '0;
	logic req_ready, rsp_valid, int_reg_block, bus_grant_n, addr_oe, data_oe;
	logic [DATA_W-1:0] rsp_rdata, data_out, data_in, mux_seen;
	logic [ADDR_W-1:0] addr_out;
	logic [NUM_CS-1:0] cs_n;
	logic memory_request_n, io_request_n, rd_n, wr_n, ale, wait_n;
	int n_errors = 0;
	int checked = 0;
	int n_st, n_mq, n_io, n_ale, n_rsp;
	always #5 mclk = ~mclk;
	always @(negedge mclk)
	begin
		n_st += !(rd_n && wr_n);
		n_mq += !memory_request_n;
		n_io += !io_request_n;
		n_ale += ale;
		n_rsp += rsp_valid;
		if (ale && data_oe)
			mux_seen = data_out;
	end
	ebms_top i_dut (.mclk, .rst_b, .req_valid, .req_ready, .req, .rsp_valid,
		.rsp_rdata, .cs_cfg, .ext_cs_match, .ext_reg_hit, .int_reg_block,
		.bus_request_n, .bus_grant_n, .addr_out, .addr_oe, .data_out,
		.data_oe, .data_in, .cs_n, .memory_request_n, .io_request_n, .rd_n,
		.wr_n, .ale, .wait_n);
	ebms_mem_model i_mem (.mclk, .addr_out, .data_out, .cs_n, .rd_n, .wr_n,
		.stall, .data_in, .wait_n);
	task test_done;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task cfg(input int cs, input ebms_fmt_t f, input logic m,
		input logic [3:0] c, input logic [2:0] w);
		@(posedge mclk);
		cs_cfg[cs] <= '{f, m, c, w};
	endtask
	task push(input int cs, input logic w, io, input logic [7:0] a, d);
		@(posedge mclk);
		req_valid <= 1'b1;
		req <= '{{16'h0000, a}, d, w, io, 4'(1 << cs)};
		do
			@(negedge mclk);
		while (req_ready !== 1'b1);
		@(posedge mclk);
		req_valid <= 1'b0;
	endtask
	task ax(input int cs, input logic w, io, input logic [7:0] a, d);
		int k;
		{n_st, n_mq, n_io, n_ale} = '0;
		push(cs, w, io, a, d);
		for (k = 0; k < 400 && rsp_valid !== 1'b1; k++)
			@(negedge mclk);
		`CHK("done", 1'b1, rsp_valid)
		if (!w)
			`CHK("rdata", d, rsp_rdata)
		`CHK("request line", io ? n_io : n_mq, n_st)
	endtask
	task t_native;
		`CHK("idle", 7'h7F, {bus_grant_n, rd_n, wr_n, cs_n})
		ax(0, 1, 0, 8'h11, 8'hA5);
		ax(0, 0, 0, 8'h11, 8'hA5);
		`CHK("native strobe", 1, n_st)
		$display("native done");
	endtask
	task t_legacy;
		cfg(1, EBMS_FMT_LEGACY, 0, 1, 0);
		ax(1, 1, 0, 8'h02, 8'h3C);
		ax(1, 0, 0, 8'h02, 8'h3C);
		`CHK("legacy strobe", 2, n_st)
		ax(1, 1, 1, 8'h03, 8'hC3);
		`CHK("io write", 2, n_io)
		cfg(1, EBMS_FMT_LEGACY, 0, 4'hF, 3'h7);
		ax(1, 0, 1, 8'h03, 8'hC3);
		`CHK("long strobe", 37, n_st)
		cfg(1, EBMS_FMT_LEGACY, 0, 3, 2);
		fork
			ax(1, 0, 0, 8'h02, 8'h3C);
			begin
				wait (rd_n === 1'b0);
				cfg(1, EBMS_FMT_LEGACY, 0, 1, 0);
			end
		join
		`CHK("held config", 8, n_st)
		$display("legacy done");
	endtask
	task t_four;
		cfg(2, EBMS_FMT_FOUR, 0, 1, 0);
		ax(2, 1, 0, 8'h04, 8'h96);
		`CHK("early data", 8'h96, mux_seen)
		ax(2, 0, 0, 8'h04, 8'h96);
		`CHK("four strobe", 4, n_st)
		`CHK("latch pulse", 1, n_ale)
		cfg(3, EBMS_FMT_FOUR, 1, 4, 0);
		ax(3, 1, 0, 8'h5A, 8'h77);
		`CHK("muxed addr", 8'h5A, mux_seen)
		`CHK("write strobe", 8, n_st)
		ax(3, 0, 0, 8'h5A, 8'h77);
		`CHK("half T1", 2, n_ale)
		ax(0, 0, 0, 8'h11, 8'hA5);
		`CHK("others kept", 1, n_st)
		$display("four done");
	endtask
	task t_wait;
		cfg(1, EBMS_FMT_LEGACY, 0, 2, 1);
		stall <= 4'h3;
		ax(1, 0, 0, 8'h02, 8'h3C);
		`CHK("legacy waits", 7, n_st)
		ax(2, 0, 0, 8'h04, 8'h96);
		`CHK("ready waits", 5, n_st)
		$display("wait done");
	endtask
	task t_grant;
		int i;
		@(posedge mclk);
		stall <= 4'h2;
		bus_request_n <= 1'b0;
		ext_reg_hit <= 1'b1;
		repeat (3) @(negedge mclk);
		`CHK("grant", 1'b0, bus_grant_n)
		`CHK("reg block", 1'b1, int_reg_block)
		for (i = 0; i < 5; i++)
		begin
			@(posedge mclk);
			ext_cs_match <= 4'(1 << i);
			@(negedge mclk);
			`CHK("master cs", ~ext_cs_match, cs_n)
		end
		for (i = 0; i < 20; i++)
		begin
			@(negedge mclk);
			if (req_ready !== 1'b1)
				break;
			push(0, 1, 0, 8'(i), 8'(i));
		end
		`CHK("fifo depth", 16, i)
		n_rsp = 0;
		repeat (3) @(negedge mclk);
		`CHK("held", 0, n_rsp)
		@(posedge mclk);
		bus_request_n <= 1'b1;
		ext_reg_hit <= 1'b0;
		repeat (300) @(negedge mclk);
		`CHK("drained", 16, n_rsp)
		`CHK("empty", 1'b1, req_ready)
		$display("grant done");
	endtask
	initial
	begin
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		t_native;
		t_legacy;
		t_four;
		t_wait;
		t_grant;
		test_done;
	end
	initial
	begin
		#100us;
		n_errors++;
		test_done;
	end
endmodule
bind ebms_top ebms_monitor i_mon (.mclk, .rst_b, .bus_request_n,
	.bus_grant_n, .ext_cs_match, .cs_n, .ext_reg_hit, .int_reg_block,
	.rd_n, .wr_n, .memory_request_n, .io_request_n, .ale, .addr_oe,
	.data_oe, .rsp_valid);
